/* File: rct_contacts.sv */
// switch contact model for the start, stop and reset inputs
// contacts move just after a rising clock edge; local pair held like reset
`timescale 1ns/1ps
`default_nettype none
module rct_contacts #(
  parameter int HOLD = 35
) (
  input  wire logic ref_clk,
  input  wire logic pressStart,
  input  wire logic pressStop,
  input  wire logic pressReset,
  input  wire logic pressLocal,
  output var logic  startIn,
  output var logic  stopIn,
  output var logic  resetIn,
  output var logic  localResetCombo
);
  int holdLeft = 0;
  int comboLeft = 0;
  // contacts open at power up
  initial begin
    startIn = 1'b0;
    stopIn = 1'b0;
    resetIn = 1'b0;
    localResetCombo = 1'b0;
  end
  // reset contact stays closed for HOLD cycles after a press
  always @(posedge ref_clk) begin
    startIn <= pressStart;
    stopIn <= pressStop;
    resetIn <= pressReset || holdLeft > 1;
    localResetCombo <= pressLocal || comboLeft > 1;
    if (pressReset) begin
      holdLeft <= HOLD;
    end else if (holdLeft > 0) begin
      holdLeft <= holdLeft - 1;
    end
    if (pressLocal) begin
      comboLeft <= HOLD;
    end else if (comboLeft > 0) begin
      comboLeft <= comboLeft - 1;
    end
  end
endmodule
`default_nettype wire

/* File: rct_pkg.sv */
// constants, state encoding and state layouts of the repeat cycle timer
// assumes a single 25 MHz clock and byte-addressed APB register access
package rct_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned TICK_CNT_W    = 25;

  // reset contact hold time, counted in time-base ticks of one second
  localparam int unsigned RESET_HOLD_S  = 3;
  localparam logic [7:0]  RESET_HOLD_TICKS = 8'(RESET_HOLD_S);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_TARGET     = 8'h04;
  localparam logic [7:0] OFS_DELAY      = 8'h08;
  localparam logic [7:0] OFS_CYCLES     = 8'h0C;
  localparam logic [7:0] OFS_CODE_ENTRY = 8'h10;
  localparam logic [7:0] OFS_CODE_STORE = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_REMAIN     = 8'h1C;

  // control field positions
  localparam int unsigned CTRL_ELAPSED  = 0;
  localparam int unsigned CTRL_OUT1_EN  = 1;
  localparam int unsigned CTRL_OUT2_EN  = 2;
  localparam int unsigned CTRL_LOCAL_EN = 3;
  localparam int unsigned CTRL_PAUSE    = 4;
  localparam int unsigned CTRL_CYCLE_EN = 5;
  localparam int unsigned CODE_EXIT_BIT = 16;

  // values after reset
  localparam logic [5:0]  CTRL_RST      = 6'h01;
  localparam logic [15:0] TARGET_RST    = 16'h0258;
  localparam logic [15:0] DELAY_RST     = 16'h0384;
  localparam logic [7:0]  CYCLES_RST    = 8'h04;
  localparam logic [15:0] CODE_RST      = 16'h0000;

  typedef enum logic [2:0] {
    ST_HALT, ST_READY, ST_RUN, ST_DELAY, ST_PAUSE, ST_DONE
  } rct_state_e;

  typedef struct packed {
    rct_state_e  state;
    logic        pausedInDelay;
    logic [15:0] mainRem;
    logic [15:0] delayRem;
    logic [7:0]  cycleCnt;
    logic [5:0]  ctrl;
    logic [15:0] targetTime;
    logic [15:0] restartDelay;
    logic [7:0]  cycleTarget;
    logic [15:0] storedCode;
    logic        menuOpen;
    logic [7:0]  holdCnt;
    logic        startPrev;
    logic        outOne;
    logic        outTwo;
    logic        resetInd;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rct_top_s;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] count;
    logic                  tick;
  } rct_tick_s;

endpackage

/* File: rct_tick_if.sv */
// carries the one-cycle time-base tick from the tick source to the timer
// assumes both ends sit on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface rct_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input  tick);
endinterface
`default_nettype wire

/* File: rct_time_base.sv */
// time-base tick source: one pulse every TICK_CYCLES clock cycles
// assumes ref_clk is free running and rst_n is asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module rct_time_base #(
  parameter int unsigned TICK_CYCLES = rct_pkg::TICK_CYCLES
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  rct_tick_if.src    tickOut
);

  localparam int unsigned CNT_W = rct_pkg::TICK_CNT_W;

  rct_pkg::rct_tick_s r, rNxt;

  // divider counts down and emits the tick on wrap
  always_comb begin
    rNxt      = r;
    rNxt.tick = 1'b0;
    if (r.count == '0) begin
      rNxt.count = CNT_W'(TICK_CYCLES - 1);
      rNxt.tick  = 1'b1;
    end else begin
      rNxt.count = r.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= rNxt;
    end
  end

  assign tickOut.tick = r.tick;

endmodule
`default_nettype wire

/* File: rct_timer.sv */
// repeat cycle timer: run period, restart delay, cycle repeat, completion
// output, reset contact hold, power-restore pause, APB register slave
// assumes contact inputs are debounced and synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module rct_timer #(
  parameter int unsigned TICK_CYCLES = rct_pkg::TICK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        startIn,
  input  wire logic        stopIn,
  input  wire logic        resetIn,
  input  wire logic        localResetCombo,
  input  wire logic        powerRestored,
  output logic             controlOutputOne,
  output logic             controlOutputTwo,
  output logic             resetIndicator
);

  rct_pkg::rct_top_s r, rNxt;
  rct_tick_if        tickBus ();

  // internal time base
  rct_time_base #(
    .TICK_CYCLES (TICK_CYCLES)
  ) timeBase (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tickOut (tickBus)
  );

  // read data mux, shared by answer and decode check
  function automatic logic [32:0] readWord(
    input rct_pkg::rct_top_s s,
    input logic [7:0]        a
  );
    logic [32:0] w;
    w = {1'b1, 32'h0000_0000};
    unique case (a)
      rct_pkg::OFS_CTRL:       w = {1'b1, 26'h0, s.ctrl};
      rct_pkg::OFS_TARGET:     w = {1'b1, 16'h0, s.targetTime};
      rct_pkg::OFS_DELAY:      w = {1'b1, 16'h0, s.restartDelay};
      rct_pkg::OFS_CYCLES:     w = {1'b1, 24'h0, s.cycleTarget};
      rct_pkg::OFS_CODE_ENTRY: w = {1'b1, 32'h0000_0000};
      rct_pkg::OFS_CODE_STORE: w = {1'b1, 32'h0000_0000};
      rct_pkg::OFS_STATUS:     w = {1'b1, 16'h0, s.cycleCnt, s.resetInd,
                                    s.outTwo, s.outOne, s.menuOpen,
                                    1'b0, s.state};
      rct_pkg::OFS_REMAIN:     w = {1'b1, s.delayRem, s.mainRem};
      default:                 w = {1'b0, 32'h0000_0000};
    endcase
    return w;
  endfunction

  logic        tick;
  logic        apbWrite;
  logic        startEdge;
  logic        resetActive;
  logic        elapsedFn;
  logic        cycleEn;
  logic [7:0]  effTarget;
  logic [32:0] rdWord;

  assign tick      = tickBus.tick;
  assign apbWrite  = psel & penable & pwrite & r.pready;
  assign startEdge = startIn & ~r.startPrev;
  assign elapsedFn = r.ctrl[rct_pkg::CTRL_ELAPSED];
  assign cycleEn   = r.ctrl[rct_pkg::CTRL_CYCLE_EN];
  // local button reset counts only when enabled
  assign resetActive = resetIn |
                       (localResetCombo & r.ctrl[rct_pkg::CTRL_LOCAL_EN]);
  // a zero target or a disabled repeat means a single cycle
  assign effTarget = (cycleEn && r.cycleTarget != 8'h00) ?
                     r.cycleTarget : 8'h01;
  assign rdWord    = readWord(r, paddr);

  // timer sequence, contacts, reset hold and register writes
  always_comb begin
    rNxt           = r;
    rNxt.startPrev = startIn;

    // time-base driven count-down
    if (tick) begin
      unique case (r.state)
        rct_pkg::ST_RUN: begin
          if (r.mainRem > 16'h0001) begin
            rNxt.mainRem = r.mainRem - 16'h0001;
          end else begin
            rNxt.mainRem  = 16'h0000;
            rNxt.cycleCnt = r.cycleCnt + 8'h01;
            if (r.cycleCnt + 8'h01 >= effTarget) begin
              rNxt.state = rct_pkg::ST_DONE;
            end else begin
              rNxt.state    = rct_pkg::ST_DELAY;
              rNxt.delayRem = r.restartDelay;
            end
          end
        end
        rct_pkg::ST_DELAY: begin
          if (r.delayRem > 16'h0001) begin
            rNxt.delayRem = r.delayRem - 16'h0001;
          end else begin
            rNxt.delayRem = 16'h0000;
            rNxt.state    = rct_pkg::ST_RUN;
            rNxt.mainRem  = r.targetTime;
          end
        end
        default: begin
        end
      endcase
    end

    // start: only from ready after reset or to resume a pause, nonzero set time, elapsed function
    if (startEdge && elapsedFn && r.targetTime != 16'h0000) begin
      if (r.state == rct_pkg::ST_READY) begin
        rNxt.state   = rct_pkg::ST_RUN;
        rNxt.mainRem = r.targetTime;
      end else if (r.state == rct_pkg::ST_PAUSE) begin
        rNxt.state = r.pausedInDelay ? rct_pkg::ST_DELAY
                                     : rct_pkg::ST_RUN;
      end
    end

    // stop contact pauses a running sequence where this cycle's tick left it
    if (stopIn && (rNxt.state == rct_pkg::ST_RUN ||
                   rNxt.state == rct_pkg::ST_DELAY)) begin
      rNxt.pausedInDelay = (rNxt.state == rct_pkg::ST_DELAY);
      rNxt.state         = rct_pkg::ST_PAUSE;
    end

    // reset contact must be held for the full hold time
    if (!resetActive) begin
      rNxt.holdCnt  = 8'h00;
      rNxt.resetInd = 1'b0;
    end else begin
      rNxt.resetInd = 1'b1;
      if (tick && r.holdCnt < rct_pkg::RESET_HOLD_TICKS) begin
        rNxt.holdCnt = r.holdCnt + 8'h01;
        if (r.holdCnt + 8'h01 == rct_pkg::RESET_HOLD_TICKS) begin
          // reset arms the timer; done state and output two are cleared
          rNxt.state    = elapsedFn ? rct_pkg::ST_READY
                                    : rct_pkg::ST_HALT;
          rNxt.mainRem  = r.targetTime;
          rNxt.delayRem = 16'h0000;
          rNxt.cycleCnt = 8'h00;
        end
      end
    end

    // register writes; settings need the menu to be open
    if (apbWrite) begin
      unique case (paddr)
        rct_pkg::OFS_CODE_ENTRY: begin
          if (pwdata[rct_pkg::CODE_EXIT_BIT]) begin
            rNxt.menuOpen = 1'b0;
          end else if (pwdata[15:0] == r.storedCode) begin
            rNxt.menuOpen = 1'b1;
          end
        end
        rct_pkg::OFS_CODE_STORE: begin
          if (r.menuOpen) begin
            rNxt.storedCode = pwdata[15:0];
          end
        end
        rct_pkg::OFS_CTRL: begin
          if (r.menuOpen) begin
            rNxt.ctrl     = pwdata[5:0];
            rNxt.state    = rct_pkg::ST_HALT;
            rNxt.mainRem  = 16'h0000;
            rNxt.delayRem = 16'h0000;
          end
        end
        rct_pkg::OFS_CYCLES: begin
          if (r.menuOpen) begin
            rNxt.cycleTarget = pwdata[7:0];
            rNxt.state       = rct_pkg::ST_HALT;
            rNxt.mainRem     = 16'h0000;
            rNxt.delayRem    = 16'h0000;
          end
        end
        rct_pkg::OFS_TARGET: begin
          if (r.menuOpen) begin
            rNxt.targetTime = pwdata[15:0];
          end
        end
        rct_pkg::OFS_DELAY: begin
          if (r.menuOpen) begin
            rNxt.restartDelay = pwdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end

    // power return: pause keeps position after any tick, else fail-safe idle
    if (powerRestored && (rNxt.state == rct_pkg::ST_RUN ||
                          rNxt.state == rct_pkg::ST_DELAY)) begin
      if (r.ctrl[rct_pkg::CTRL_PAUSE]) begin
        rNxt.pausedInDelay = (rNxt.state == rct_pkg::ST_DELAY);
        rNxt.state         = rct_pkg::ST_PAUSE;
      end else begin
        rNxt.state = rct_pkg::ST_HALT;
      end
    end

    // clock function suspends the timer entirely
    if (!rNxt.ctrl[rct_pkg::CTRL_ELAPSED]) begin
      rNxt.state = rct_pkg::ST_HALT;
    end

    // outputs follow the next state, gated by their enables
    rNxt.outOne = rNxt.ctrl[rct_pkg::CTRL_OUT1_EN] &
                  (rNxt.state == rct_pkg::ST_RUN);
    rNxt.outTwo = rNxt.ctrl[rct_pkg::CTRL_OUT2_EN] &
                  (rNxt.state == rct_pkg::ST_DONE);

    // apb answer one cycle into the access phase
    rNxt.pready  = psel & penable & ~r.pready;
    rNxt.pslverr = psel & penable & ~r.pready & ~rdWord[32];
    if (psel && penable && !r.pready && !pwrite) begin
      rNxt.prdata = rdWord[31:0];
    end else begin
      rNxt.prdata = 32'h0000_0000;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r              <= '0;
      r.state        <= rct_pkg::ST_HALT;
      r.ctrl         <= rct_pkg::CTRL_RST;
      r.targetTime   <= rct_pkg::TARGET_RST;
      r.restartDelay <= rct_pkg::DELAY_RST;
      r.cycleTarget  <= rct_pkg::CYCLES_RST;
      r.storedCode   <= rct_pkg::CODE_RST;
    end else begin
      r <= rNxt;
    end
  end

  // ports straight from the state register
  assign prdata           = r.prdata;
  assign pready           = r.pready;
  assign pslverr          = r.pslverr;
  assign controlOutputOne = r.outOne;
  assign controlOutputTwo = r.outTwo;
  assign resetIndicator   = r.resetInd;

endmodule
`default_nettype wire

/* File: rct_timer_asserts.sv */
// port-level assertions for the repeat cycle timer
// bound to rct_timer; sees only its ports, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rct_timer_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        startIn,
  input wire logic        stopIn,
  input wire logic        resetIn,
  input wire logic        localResetCombo,
  input wire logic        powerRestored,
  input wire logic        controlOutputOne,
  input wire logic        controlOutputTwo,
  input wire logic        resetIndicator
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // first access cycle, then exactly one wait state
  sequence accBegin;
    psel && penable && !$past(penable);
  endsequence
  sequence oneWait;
    !pready ##1 pready;
  endsequence
  // neither reset source is held
  sequence noHold;
    !resetIn && !localResetCombo;
  endsequence
  property outsApart;
    !(controlOutputOne && controlOutputTwo);
  endproperty
  property powerOff;
    powerRestored |=> !controlOutputOne;
  endproperty
  property out2Holds;
    controlOutputTwo && !resetIn && !localResetCombo && !(pready && pwrite)
      |=> controlOutputTwo;
  endproperty
  pready_wait_a: assert property (accBegin |-> oneWait)
    else $error("pready not after one wait");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  ind_follow_a: assert property (resetIn |=> resetIndicator)
    else $error("reset indicator missing");
  ind_drop_a: assert property (noHold |=> !resetIndicator)
    else $error("reset indicator stuck");
  outs_apart_a: assert property (outsApart)
    else $error("both outputs closed");
  power_off_a: assert property (powerOff)
    else $error("output one on after power return");
  out2_hold_a: assert property (out2Holds)
    else $error("output two dropped without reset");
  stop_pause_a: assert property (stopIn |=> !controlOutputOne)
    else $error("output one on while stop held");
endmodule
bind rct_timer rct_timer_asserts chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .startIn(startIn),
  .stopIn(stopIn), .resetIn(resetIn), .localResetCombo(localResetCombo),
  .powerRestored(powerRestored), .controlOutputOne(controlOutputOne),
  .controlOutputTwo(controlOutputTwo), .resetIndicator(resetIndicator));
`default_nettype wire

/* File: repeat_cycle_timer_tb.sv */
// self-checking bench for the repeat cycle timer
// one 25 MHz clock; contacts come from rct_contacts
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; \
  if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module repeat_cycle_timer_tb;
  localparam int         TC = 10;
  localparam logic [7:0] ST = rct_pkg::OFS_STATUS;
  localparam logic [7:0] RM = rct_pkg::OFS_REMAIN;
  logic        clk = 1'b0, rstN = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pwrOn = 1'b0, pStart = 1'b0, pReset = 1'b0;
  logic        pStop = 1'b0, pLocal = 1'b0;
  logic        pready, pslverr, out1, out2, ind, sIn, tIn, rIn, cIn, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, m;
  int          num_errors = 0, checks_done = 0, cyc = 0, t0;
  rct_contacts #(.HOLD(35)) MDL (.ref_clk(clk), .pressStart(pStart),
    .pressStop(pStop), .pressReset(pReset), .pressLocal(pLocal),
    .startIn(sIn), .stopIn(tIn), .resetIn(rIn), .localResetCombo(cIn));
  rct_timer #(.TICK_CYCLES(TC)) DUT (.ref_clk(clk), .rst_n(rstN),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startIn(sIn), .stopIn(tIn), .resetIn(rIn),
    .localResetCombo(cIn), .powerRestored(pwrOn),
    .controlOutputOne(out1), .controlOutputTwo(out2),
    .resetIndicator(ind));
  // 40 ns clock and a hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] msk, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & msk)
  endtask
  // contact presses through the model
  task automatic press();
    pStart <= 1'b1;
    repeat (3) @(posedge clk);
    pStart <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic holdReset(input logic loc = 1'b0, input logic e = 1'b1);
    if (loc) begin
      pLocal <= 1'b1;
    end else begin
      pReset <= 1'b1;
    end
    @(posedge clk);
    pReset <= 1'b0;
    pLocal <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("ind", e, ind)
    repeat (40) @(posedge clk);
  endtask
  task automatic waitOut(input logic v);
    while (out1 !== v) @(posedge clk);
  endtask
  // reset values, unmapped access, menu lock
  task automatic t_regs();
    rdchk("ctrl", rct_pkg::OFS_CTRL, 32'h3F, 32'h01);
    rdchk("tgt", rct_pkg::OFS_TARGET, 32'hFFFF, 32'h258);
    rdchk("dly", rct_pkg::OFS_DELAY, 32'hFFFF, 32'h384);
    rdchk("cyc", rct_pkg::OFS_CYCLES, 32'hFF, 32'h04);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    wr(rct_pkg::OFS_TARGET, 32'h3);
    rdchk("lock", rct_pkg::OFS_TARGET, 32'hFFFF, 32'h258);
    wr(rct_pkg::OFS_CODE_ENTRY, 32'h1234);
    rdchk("bad code", ST, 32'h10, 32'h0);
    wr(rct_pkg::OFS_CODE_ENTRY, 32'h0);
    rdchk("menu", ST, 32'h10, 32'h10);
  endtask
  // two short cycles with a restart delay, then completion
  task automatic t_cycle();
    wr(rct_pkg::OFS_TARGET, 32'h3);
    wr(rct_pkg::OFS_DELAY, 32'h2);
    wr(rct_pkg::OFS_CYCLES, 32'h2);
    wr(rct_pkg::OFS_CTRL, 32'h37);
    press();
    rdchk("no reset", ST, 32'h7, 32'h0);
    holdReset();
    rdchk("ready", ST, 32'h7, 32'h1);
    pStart <= 1'b1;
    waitOut(1'b1);
    t0 = cyc;
    pStart <= 1'b0;
    waitOut(1'b0);
    `CHK("run", 1'b1, cyc - t0 > 2 * TC && cyc - t0 <= 3 * TC)
    t0 = cyc;
    rdchk("dly rem", RM, 32'hFFFF0000, 32'h20000);
    rdchk("count", ST, 32'hFF00, 32'h100);
    waitOut(1'b1);
    `CHK("delay", 2 * TC, cyc - t0)
    t0 = cyc;
    waitOut(1'b0);
    `CHK("run2", 3 * TC, cyc - t0)
    `CHK("done out", 1'b1, out2)
    rdchk("count2", ST, 32'hFF07, 32'h205);
    holdReset();
    `CHK("out2 off", 1'b0, out2)
  endtask
  // power return with pause option, then resume from position
  task automatic t_power();
    holdReset();
    pStart <= 1'b1;
    waitOut(1'b1);
    pStart <= 1'b0;
    repeat (12) @(posedge clk);
    pwrOn <= 1'b1;
    @(posedge clk) pwrOn <= 1'b0;
    @(posedge clk);
    `CHK("paused out", 1'b0, out1)
    rdchk("pause", ST, 32'h7, 32'h4);
    apb(1'b0, RM, 32'h0);
    m = rd;
    `CHK("paused rem", 1'b1, m[15:0] != 16'h0 && m[15:0] < 16'h3)
    repeat (30) @(posedge clk);
    `CHK("still off", 1'b0, out1)
    pStart <= 1'b1;
    waitOut(1'b1);
    t0 = cyc;
    pStart <= 1'b0;
    waitOut(1'b0);
    `CHK("resume", 1'b1, cyc - t0 <= m[15:0] * TC)
    `CHK("resume lo", 1'b1, cyc - t0 > (m[15:0] - 1) * TC)
  endtask
  // local reset pair, stop contact, power return without pause
  task automatic t_stop();
    wr(rct_pkg::OFS_CTRL, 32'h37);
    holdReset(1'b1, 1'b0);
    rdchk("combo off", ST, 32'h7, 32'h0);
    wr(rct_pkg::OFS_CTRL, 32'h3F);
    holdReset(1'b1, 1'b1);
    rdchk("combo on", ST, 32'h7, 32'h1);
    press();
    `CHK("run on", 1'b1, out1)
    pStop <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("stop out", 1'b0, out1)
    pStop <= 1'b0;
    rdchk("stopped", ST, 32'h7, 32'h4);
    press();
    rdchk("resumed", ST, 32'h7, 32'h2);
    wr(rct_pkg::OFS_CTRL, 32'h2F);
    holdReset();
    press();
    `CHK("run on2", 1'b1, out1)
    pwrOn <= 1'b1;
    @(posedge clk);
    pwrOn <= 1'b0;
    @(posedge clk);
    `CHK("pwr out", 1'b0, out1)
    rdchk("pwr halt", ST, 32'h7, 32'h0);
  endtask
  // fail-safe halt, output enable, zero set time, function off
  task automatic t_guards();
    wr(rct_pkg::OFS_CTRL, 32'h35);
    rdchk("halt", ST, 32'h7, 32'h0);
    holdReset();
    press();
    rdchk("run dis", ST, 32'h7, 32'h2);
    `CHK("out1 dis", 1'b0, out1)
    wr(rct_pkg::OFS_TARGET, 32'h0);
    rdchk("tgt keep", ST, 32'h7, 32'h2);
    wr(rct_pkg::OFS_CTRL, 32'h37);
    holdReset();
    press();
    rdchk("zero", ST, 32'h7, 32'h1);
    wr(rct_pkg::OFS_CTRL, 32'h36);
    holdReset();
    rdchk("fn off", ST, 32'h7, 32'h0);
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (3) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    t_regs();
    t_cycle();
    t_power();
    t_stop();
    t_guards();
    wrap_up();
  end
endmodule
`default_nettype wire
